/* shared/sss_pkg.sv */
// Constants and types shared by the stream scan sequencer files.
// Assumes a single 50 MHz clock domain.
package sss_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Channel gap per conversion speed index, in nanoseconds
    localparam int GAP0_NS = 320000;
    localparam int GAP1_NS = 82000;
    localparam int GAP2_NS = 42000;
    localparam int GAP3_NS = 12500;
    // Gap lengths in clock cycles, rounded down
    localparam int GAP0_CYCLES = GAP0_NS / CLK_PERIOD_NS;
    localparam int GAP1_CYCLES = GAP1_NS / CLK_PERIOD_NS;
    localparam int GAP2_CYCLES = GAP2_NS / CLK_PERIOD_NS;
    localparam int GAP3_CYCLES = GAP3_NS / CLK_PERIOD_NS;
    // Documented buffer capacities in samples
    localparam int DOC_FIFO_NORMAL = 984;
    localparam int DOC_FIFO_SMALLEST = 512;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 16;
    localparam logic [7:0] SAMPLES_PER_PACKET = 8'h19;
    localparam int LIST_DEPTH = 16;
    localparam int TC_UNITS = 4;
    // Special scan-list entry codes
    localparam logic [7:0] CH_EXT_FLEX_WORD = 8'hc1;
    localparam logic [7:0] CH_CONTROL_WORD = 8'hc2;
    localparam logic [7:0] CH_TIMER_BASE = 8'hc8;
    localparam logic [7:0] CH_COUNTER_BASE = 8'hd2;
    localparam logic [7:0] CH_CAPTURE = 8'he0;
    localparam logic [7:0] CH_TIMER_RST_BASE = 8'he6;
    localparam logic [7:0] CH_COUNTER_RST_BASE = 8'hf0;
    // Timer mode that cannot be streamed
    localparam logic [3:0] MODE_SYSTIMER_HIGH = 4'hb;
    // Reset values
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [15:0] DROPPED_RESET = 16'h0000;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0001;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLOT,
        ST_CONV,
        ST_GAP,
        ST_WAIT
    } sss_state_t;
endpackage

/* hdl/sss_fifo.sv */
// Sample FIFO with registered outputs, valid and ready on both sides.
// Assumes the reader holds outReady only when it can take a word.
`timescale 1ns/1ps
`default_nettype none
module sss_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] memReg [DEPTH];
    logic [AW-1:0] wrPtr_reg, rdPtr_reg;
    logic [AW:0] count_reg, count_next, afterPop;
    logic push, pop;
    logic [AW-1:0] rdPtr_next;

    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign afterPop = count_reg - {{AW{1'b0}}, pop};
    assign count_next = afterPop + {{AW{1'b0}}, push};
    assign rdPtr_next = rdPtr_reg + {{(AW-1){1'b0}}, pop};

    always_ff @(posedge clk) begin
        if (push) begin
            memReg[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady <= 1'b1;
            outValid <= 1'b0;
            outData <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, push};
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
            inReady <= (count_next != DEPTH[AW:0]);
            outValid <= (count_next != '0);
            // Word entering an empty store goes straight to the output
            outData <= (push && afterPop == '0) ? inData : memReg[rdPtr_next];
        end
    end
endmodule
`default_nettype wire

/* hdl/sss_tc_bank.sv */
// Two timers and two counters of 32 bits, sampled and cleared by the sequencer.
// Assumes unit events arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module sss_tc_bank
    import sss_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [TC_UNITS-1:0] unitEvent,
    input wire logic [1:0] selUnit,
    input wire logic clearSel,
    output logic [15:0] lowWord,
    output logic [15:0] highWord
);
    logic [31:0] unitReg [TC_UNITS];

    genvar u;
    generate
        for (u = 0; u < TC_UNITS; u++) begin : g_unit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    unitReg[u] <= 32'h0000_0000;
                end else if (clearSel && selUnit == 2'(u)) begin
                    unitReg[u] <= 32'h0000_0000;
                end else if (unitEvent[u]) begin
                    unitReg[u] <= unitReg[u] + 32'h0000_0001;
                end
            end
        end
    endgenerate

    assign lowWord = unitReg[selUnit][15:0];
    assign highWord = unitReg[selUnit][31:16];
endmodule
`default_nettype wire

/* hdl/sss_stream_sequencer.sv */
// Hardware-timed stream scan sequencer: scan list, channel timing,
// special digital and timer/counter entries, overflow auto-recovery.
// Assumes one 50 MHz clock; host drains the FIFO and keeps rate limits.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module sss_stream_sequencer
    import sss_pkg::*;
#(
    parameter int GAP0_CNT = GAP0_CYCLES,
    parameter int GAP1_CNT = GAP1_CYCLES,
    parameter int GAP2_CNT = GAP2_CYCLES,
    parameter int GAP3_CNT = GAP3_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic setupStart,
    input wire logic setupStop,
    input wire logic [1:0] conversionSpeedIndex,
    input wire logic [31:0] scanPeriodCycles,
    input wire logic [4:0] listLength,
    input wire logic listWrEn,
    input wire logic [3:0] listWrAddr,
    input wire logic [7:0] listWrData,
    output logic adcStart,
    output logic [7:0] adcChannel,
    output logic [1:0] adcSpeedIndex,
    input wire logic adcDone,
    input wire logic [15:0] adcData,
    input wire logic [7:0] flexiblePortBits,
    input wire logic [7:0] extendedPortBits,
    input wire logic [7:0] controlPortDigitalByte,
    input wire logic [TC_UNITS-1:0] unitEvent,
    input wire logic [3:0] timerMode0,
    input wire logic [3:0] timerMode1,
    output logic outValid,
    input wire logic outReady,
    output logic [15:0] outData,
    output logic streamRunning,
    output logic recovering,
    output logic [15:0] droppedPackets,
    output logic unreadableEntry
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    sss_state_t state_reg, state_next;
    logic [7:0] listReg [LIST_DEPTH];
    logic [3:0] entryIdx_reg;
    logic [4:0] lenReg;
    logic [31:0] periodReg, periodCnt_reg;
    logic [15:0] gapCnt_reg;
    logic [1:0] speed_reg;
    logic [15:0] capture_reg;
    logic sampleValid_reg;
    logic [15:0] sampleData_reg;
    logic [7:0] dropCnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the current entry
    logic [7:0] entry;
    logic isExtFlex, isControl, isCapture;
    logic isTimer, isCounter, isTimerRst, isCounterRst, isTc, isRstEntry, isAnalog;
    logic [1:0] tcUnit;
    logic [3:0] selMode;
    logic modeBlocked;
    logic [15:0] tcLow, tcHigh;
    logic [15:0] specialData;
    logic [15:0] gapLoad;
    logic tick, lastEntry, slotPulse, tcSample, fifoInReady;
    logic dropNow, fifoEmpty;

    assign entry = listReg[entryIdx_reg];
    assign isExtFlex = (entry == CH_EXT_FLEX_WORD);
    assign isControl = (entry == CH_CONTROL_WORD);
    assign isCapture = (entry == CH_CAPTURE);
    assign isTimer = (entry[7:1] == CH_TIMER_BASE[7:1]);
    assign isCounter = (entry[7:1] == CH_COUNTER_BASE[7:1]);
    assign isTimerRst = (entry[7:1] == CH_TIMER_RST_BASE[7:1]);
    assign isCounterRst = (entry[7:1] == CH_COUNTER_RST_BASE[7:1]);
    assign isRstEntry = isTimerRst | isCounterRst;
    assign isTc = isTimer | isCounter | isRstEntry;
    assign isAnalog = ~(isExtFlex | isControl | isCapture | isTc);
    assign tcUnit = {isCounter | isCounterRst, entry[0]};
    assign selMode = entry[0] ? timerMode1 : timerMode0;
    assign modeBlocked = (isTimer | isTimerRst) && (selMode == MODE_SYSTIMER_HIGH);
    assign slotPulse = (state_reg == ST_SLOT);
    assign tcSample = slotPulse & isTc & ~modeBlocked;

    // Digital words read input states only, whatever the pin use
    assign specialData =
        isExtFlex ? {extendedPortBits, flexiblePortBits} :
        isControl ? {8'h00, controlPortDigitalByte} :
        isCapture ? capture_reg :
        modeBlocked ? 16'h0000 :
        tcLow;

    // Gap length by speed index
    assign gapLoad = (speed_reg == 2'd0) ? GAP0_CNT[15:0] :
                     (speed_reg == 2'd1) ? GAP1_CNT[15:0] :
                     (speed_reg == 2'd2) ? GAP2_CNT[15:0] : GAP3_CNT[15:0];

    assign tick = streamRunning && (periodCnt_reg == 32'h0000_0000);
    assign lastEntry = ({1'b0, entryIdx_reg} + 5'd1 >= lenReg);

    ////////////////////////////////////////////////////////////////////////////
    // Timer and counter bank
    sss_tc_bank u_tc (
        .clk(clk),
        .sys_rst(sys_rst),
        .unitEvent(unitEvent),
        .selUnit(tcUnit),
        .clearSel(tcSample & isRstEntry),
        .lowWord(tcLow),
        .highWord(tcHigh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Scan list storage and stream setup
    always_ff @(posedge clk) begin
        if (listWrEn) begin
            listReg[listWrAddr] <= listWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            speed_reg <= 2'd0;
            periodReg <= PERIOD_RESET;
            lenReg <= 5'd1;
        end else if (setupStart && !streamRunning) begin
            speed_reg <= conversionSpeedIndex;
            periodReg <= (scanPeriodCycles == 32'h0) ? PERIOD_RESET : scanPeriodCycles;
            lenReg <= (listLength == 5'd0) ? 5'd1 : listLength;
        end
    end

    assign adcSpeedIndex = speed_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Scan period timer, start to start
    always_ff @(posedge clk) begin
        if (sys_rst || !streamRunning) begin
            periodCnt_reg <= 32'h0000_0000;
        end else if (tick) begin
            periodCnt_reg <= periodReg - 32'h0000_0001;
        end else begin
            periodCnt_reg <= periodCnt_reg - 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                state_next = ST_IDLE;
            end
            ST_SLOT: begin
                state_next = isAnalog ? ST_CONV : ST_GAP;
            end
            ST_CONV: begin
                if (adcDone) begin
                    state_next = ST_GAP;
                end
            end
            ST_GAP: begin
                if (gapCnt_reg == 16'h0000) begin
                    state_next = lastEntry ? ST_WAIT : ST_SLOT;
                end
            end
            ST_WAIT: begin
                state_next = ST_WAIT;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (streamRunning && tick) begin
            state_next = ST_SLOT;
        end
        if (setupStop) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            streamRunning <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (setupStop) begin
                streamRunning <= 1'b0;
            end else if (setupStart) begin
                streamRunning <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            entryIdx_reg <= 4'h0;
        end else if (tick) begin
            entryIdx_reg <= 4'h0;
        end else if (state_reg == ST_GAP && gapCnt_reg == 16'h0000 && !lastEntry) begin
            entryIdx_reg <= entryIdx_reg + 4'h1;
        end
    end

    // Gap runs from the start of each slot, analog or special
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gapCnt_reg <= 16'h0000;
        end else if (slotPulse) begin
            gapCnt_reg <= gapLoad - 16'h0002;
        end else if (gapCnt_reg != 16'h0000) begin
            gapCnt_reg <= gapCnt_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adcStart <= 1'b0;
            adcChannel <= 8'h00;
        end else begin
            adcStart <= slotPulse & isAnalog & ~tick;
            adcChannel <= slotPulse ? entry : adcChannel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample capture and upper-word latch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sampleValid_reg <= 1'b0;
            sampleData_reg <= 16'h0000;
        end else if (slotPulse && !isAnalog) begin
            sampleValid_reg <= 1'b1;
            sampleData_reg <= specialData;
        end else if (state_reg == ST_CONV && adcDone) begin
            sampleValid_reg <= 1'b1;
            sampleData_reg <= adcData;
        end else begin
            sampleValid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capture_reg <= CAPTURE_RESET;
        end else if (tcSample) begin
            capture_reg <= tcHigh;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unreadableEntry <= 1'b0;
        end else if (setupStart && !streamRunning) begin
            unreadableEntry <= 1'b0;
        end else if (slotPulse && modeBlocked) begin
            unreadableEntry <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO and overflow auto-recovery
    assign dropNow = sampleValid_reg & (recovering | ~fifoInReady);
    assign fifoEmpty = ~outValid;

    sss_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(sampleValid_reg & ~recovering),
        .inReady(fifoInReady),
        .inData(sampleData_reg),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outData)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            recovering <= 1'b0;
        end else if (sampleValid_reg && !fifoInReady) begin
            recovering <= 1'b1;
        end else if (fifoEmpty) begin
            recovering <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (setupStart && !streamRunning)) begin
            dropCnt_reg <= 8'h00;
            droppedPackets <= DROPPED_RESET;
        end else if (dropNow) begin
            dropCnt_reg <= (dropCnt_reg == SAMPLES_PER_PACKET - 8'h01) ? 8'h00
                           : dropCnt_reg + 8'h01;
            if (dropCnt_reg == 8'h00) begin
                droppedPackets <= droppedPackets + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/sss_stream_sequencer_chk.sv */
// Port-level checks of the stream scan sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sss_stream_sequencer_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic setupStart,
    input wire logic setupStop,
    input wire logic [1:0] conversionSpeedIndex,
    input wire logic adcStart,
    input wire logic [1:0] adcSpeedIndex,
    input wire logic outValid,
    input wire logic outReady,
    input wire logic [15:0] outData,
    input wire logic streamRunning,
    input wire logic recovering,
    input wire logic [15:0] droppedPackets,
    input wire logic unreadableEntry
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Start request accepted while idle
    sequence accepted_start;
        setupStart && !setupStop && !streamRunning;
    endsequence
    // Host holding off a waiting word
    sequence host_stall;
        outValid && !outReady;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_start_runs: assert property (accepted_start |=> streamRunning)
        else $error("Stream did not start");
    a_stop_halts: assert property (setupStop |=> !streamRunning)
        else $error("Stream did not stop");
    a_conv_spacing: assert property (adcStart |=> !adcStart [*2])
        else $error("Conversion starts too close");
    a_speed_latch: assert property (accepted_start |=> adcSpeedIndex == $past(conversionSpeedIndex))
        else $error("Speed index not latched");
    a_fifo_hold: assert property (host_stall |=> outValid && $stable(outData))
        else $error("Stalled word lost or changed");
    a_recover_end: assert property (recovering && !outValid |=> !recovering)
        else $error("Recovery not ended after drain");
    a_sticky_flag: assert property (unreadableEntry && !setupStart |=> unreadableEntry)
        else $error("Unreadable flag dropped");
    a_start_clears: assert property (accepted_start |=> !unreadableEntry && droppedPackets == 16'h0000)
        else $error("Start did not clear status");
endmodule
bind sss_stream_sequencer sss_stream_sequencer_chk i_sss_stream_sequencer_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .setupStart(setupStart),
    .setupStop(setupStop),
    .conversionSpeedIndex(conversionSpeedIndex),
    .adcStart(adcStart),
    .adcSpeedIndex(adcSpeedIndex),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outData),
    .streamRunning(streamRunning),
    .recovering(recovering),
    .droppedPackets(droppedPackets),
    .unreadableEntry(unreadableEntry)
);
`default_nettype wire

/* verification/sss_host_model.sv */
// Far side: host draining the sample FIFO and a converter answering starts.
// Assumes the clock and reset of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic drainEn,
    input wire logic adcSlow,
    input wire logic adcStart,
    input wire logic [7:0] adcChannel,
    output logic adcDone,
    output logic [15:0] adcData,
    output logic outReady
);
    logic busyReg;
    logic [3:0] waitReg;
    logic [7:0] chanReg;
    // Converter answers after 2 or 12 cycles
    always_ff @(posedge clk) begin
        if (sys_rst || adcStart) begin
            busyReg <= !sys_rst;
            waitReg <= adcSlow ? 4'hb : 4'h1;
            chanReg <= adcChannel;
        end else if (busyReg && waitReg != 4'h0) begin
            waitReg <= waitReg - 4'h1;
        end else begin
            busyReg <= 1'b0;
        end
    end
    assign adcDone = busyReg && waitReg == 4'h0;
    // Data only valid in the done cycle
    assign adcData = adcDone ? {8'ha5, chanReg} : {8'h5a, ~chanReg};
    // Host takes words while its drain is on
    assign outReady = drainEn;
endmodule
`default_nettype wire

/* verification/test_sss_stream_sequencer.sv */
// Self-checking bench of the stream scan sequencer.
// Assumes shortened gap counts; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module test_sss_stream_sequencer
    import sss_pkg::*;
;
    logic clk, sys_rst, setupStart, setupStop, listWrEn, adcStart, adcDone, outValid;
    logic outReady, streamRunning, recovering, unreadableEntry, drainEn, adcSlow;
    logic [1:0] speedIdx, adcSpeedIndex;
    logic [31:0] period;
    logic [4:0] listLen;
    logic [3:0] wrAddr, timerMode0;
    logic [7:0] wrData, adcChannel, flexBits, extBits, ctrlBits;
    logic [15:0] adcData, outData, droppedPackets;
    logic [TC_UNITS-1:0] unitEvent;
    logic [15:0] got[$];
    int failures, comparisons, cycles;
    sss_stream_sequencer #(.GAP0_CNT(8), .GAP1_CNT(6), .GAP2_CNT(4), .GAP3_CNT(3))
    i_sss_stream_sequencer (
        .clk(clk),
        .sys_rst(sys_rst),
        .setupStart(setupStart),
        .setupStop(setupStop),
        .conversionSpeedIndex(speedIdx),
        .scanPeriodCycles(period),
        .listLength(listLen),
        .listWrEn(listWrEn),
        .listWrAddr(wrAddr),
        .listWrData(wrData),
        .adcStart(adcStart),
        .adcChannel(adcChannel),
        .adcSpeedIndex(adcSpeedIndex),
        .adcDone(adcDone),
        .adcData(adcData),
        .flexiblePortBits(flexBits),
        .extendedPortBits(extBits),
        .controlPortDigitalByte(ctrlBits),
        .unitEvent(unitEvent),
        .timerMode0(timerMode0),
        .timerMode1(4'h0),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outData),
        .streamRunning(streamRunning),
        .recovering(recovering),
        .droppedPackets(droppedPackets),
        .unreadableEntry(unreadableEntry)
    );
    sss_host_model i_sss_host_model (
        .clk(clk),
        .sys_rst(sys_rst),
        .drainEn(drainEn),
        .adcSlow(adcSlow),
        .adcStart(adcStart),
        .adcChannel(adcChannel),
        .adcDone(adcDone),
        .adcData(adcData),
        .outReady(outReady)
    );
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (!sys_rst && outValid === 1'b1 && outReady === 1'b1) begin
            got.push_back(outData);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        listWrEn = 1'b1;
        wrAddr = a;
        wrData = d;
        tick(1);
        listWrEn = 1'b0;
        tick(1);
    endtask
    task automatic start(input logic [1:0] sp, input logic [31:0] per, input logic [4:0] len);
        speedIdx = sp;
        period = per;
        listLen = len;
        setupStart = 1'b1;
        tick(1);
        setupStart = 1'b0;
        tick(1);
    endtask
    task automatic stop_stream();
        setupStop = 1'b1;
        tick(1);
        setupStop = 1'b0;
        tick(6);
        got.delete();
    endtask
    task automatic wait_words(input int n);
        int k;
        k = 0;
        while (got.size() < n && k < 3000) begin
            tick(1);
            k++;
        end
        check("word count", 16'(got.size()), 16'(n));
    endtask
    task automatic pulse_unit0();
        unitEvent = 4'h1;
        tick(1);
        unitEvent = 4'h0;
        tick(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_special();
        logic [15:0] exp [7];
        exp = '{16'hc33c, 16'h0096, 16'h0005, 16'h0000, 16'h0005, 16'h0000, 16'ha505};
        wr(4'h0, CH_EXT_FLEX_WORD);
        wr(4'h1, CH_CONTROL_WORD);
        wr(4'h2, CH_TIMER_BASE);
        wr(4'h3, CH_CAPTURE);
        wr(4'h4, CH_TIMER_RST_BASE);
        wr(4'h5, CH_CAPTURE);
        wr(4'h6, 8'h05);
        repeat (5) pulse_unit0();
        drainEn = 1'b1;
        adcSlow = 1'b1;
        start(2'h3, 32'd200, 5'd7);
        wait_words(14);
        for (int i = 0; i < 14; i++) begin
            check("scan word", got[i], (i == 9 || i == 11) ? 16'h0000 : exp[i % 7]);
        end
        stop_stream();
        $display("test_special done");
    endtask
    task automatic test_overflow();
        int k;
        wr(4'h0, 8'h05);
        wr(4'h1, 8'h06);
        drainEn = 1'b0;
        adcSlow = 1'b0;
        start(2'h3, 32'd20, 5'd2);
        k = 0;
        while (recovering !== 1'b1 && k < 2000) begin
            tick(1);
            k++;
        end
        check("recovering", {15'h0000, recovering}, 16'h0001);
        tick(100);
        drainEn = 1'b1;
        k = 0;
        while (recovering === 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        check("words before resume", 16'(got.size()), 16'(FIFO_DEPTH));
        check("dropped packets", droppedPackets, 16'h0001);
        wait_words(FIFO_DEPTH + 4);
        stop_stream();
        $display("test_overflow done");
    endtask
    task automatic test_speeds();
        int n;
        for (int s = 0; s < 4; s++) begin
            start(s[1:0], 32'd60, 5'd2);
            check("speed index", {14'h0000, adcSpeedIndex}, 16'(s));
            check("drops cleared", droppedPackets, 16'h0000);
            n = 0;
            while (adcStart !== 1'b1 && n < 50) begin
                tick(1);
                n++;
            end
            tick(1);
            n = 1;
            while (adcStart !== 1'b1 && n < 50) begin
                tick(1);
                n++;
            end
            check("channel gap", 16'(n), (s == 0) ? 16'h0008 : (s == 1) ? 16'h0006 : 16'h0005);
            tick(130);
            stop_stream();
        end
        $display("test_speeds done");
    endtask
    task automatic test_mode11();
        wr(4'h0, CH_TIMER_BASE);
        pulse_unit0();
        timerMode0 = MODE_SYSTIMER_HIGH;
        start(2'h3, 32'd40, 5'd1);
        wait_words(1);
        check("mode 11 word", got[0], 16'h0000);
        check("unreadable flag", {15'h0000, unreadableEntry}, 16'h0001);
        stop_stream();
        timerMode0 = 4'h0;
        $display("test_mode11 done");
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {setupStart, setupStop, listWrEn, drainEn, adcSlow} = 5'h00;
        speedIdx = 2'h0;
        period = 32'h0000_0001;
        listLen = 5'h01;
        wrAddr = 4'h0;
        wrData = 8'h00;
        timerMode0 = 4'h0;
        unitEvent = 4'h0;
        {flexBits, extBits, ctrlBits} = 24'h3cc396;
        sys_rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        tick(1);
        check("idle flags", {12'h000, outValid, streamRunning, recovering, unreadableEntry}, 16'h0000);
        check("reset drops", droppedPackets, 16'h0000);
        test_special();
        test_overflow();
        test_speeds();
        test_mode11();
        print_verdict();
    end
endmodule
`default_nettype wire
